// ### hw/acsp_host.sv
/*
  acsp_host: host-side controller driving the converter's setup port,
  readback and result handshake. software reaches it over apb.
  assumes: device pins are asynchronous to clk_sys; clk_sys 200 MHz.
*/
`timescale 1ns/100ps
// What this block does
// - hold toggle low, pulse reset, then shift
// - msb first, device samples on falling edge
// - always send all twelve setup bits
// - toggle integrate after setup to start
// - wait 2 us after reset release
// - wait 2 us between write and readback
// - reset held low at least 1 us
// - discard results of first four conversions
// - read results only after ready goes low
// - chain input tied low for single device
// - park readout clock low around toggles
module acsp_host
  import acsp_pkg::*;
#(
  parameter int unsigned HALF = HALF_CYC
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output acsp_pins_out_type pins,
  input  wire logic        readout_data_out,
  input  wire logic        result_ready_n
);

  acsp_state_type state;
  logic [11:0] setup_word;
  logic [1:0]  sync_rd;
  logic [1:0]  sync_rdy;
  logic [15:0] tmr;
  logic [9:0]  bit_cnt;
  logic [31:0] rb_shift;
  logic        rb_avail;
  logic        rb_done;
  logic        do_write;
  logic        do_read;
  logic        do_start;
  logic        do_step;
  logic        rdy_seen;
  logic [2:0]  integrate_toggle_cnt;
  logic        sclk;
  logic        half_tick;
  logic        apb_wr;
  logic        apb_rd;
  logic [9:0]  rb_total;

  assign apb_wr    = psel && penable && pwrite;
  assign apb_rd    = psel && penable && !pwrite;
  assign half_tick = (tmr == 16'(HALF - 1));
  assign rb_total  = setup_word[F_WIDTH] ? 10'(RB_BITS_20) : 10'(RB_BITS_16);

  // two-flop synchronisers for device outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_rd  <= 2'h0;
      sync_rdy <= 2'h3;
    end
    else if (clk_en)
    begin
      sync_rd  <= {sync_rd[0], readout_data_out};
      sync_rdy <= {sync_rdy[0], result_ready_n};
    end
  end

  // apb slave: zero wait states, unmapped offsets answer with pslverr
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_word <= SETUP_RESET;
      do_write   <= 1'b0;
      do_read    <= 1'b0;
      do_start   <= 1'b0;
      do_step    <= 1'b0;
      prdata     <= 32'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end
    else if (clk_en)
    begin
      do_write <= 1'b0;
      do_read  <= 1'b0;
      do_start <= 1'b0;
      do_step  <= 1'b0;
      pready   <= psel && !penable;
      pslverr  <= 1'b0;
      if (psel && !penable)
      begin
        pslverr <= !(paddr inside {REG_SETUP, REG_CTRL, REG_STATUS, REG_RBDATA, REG_COUNT});
        case (paddr)
          REG_SETUP:  prdata <= {20'h0, setup_word};
          REG_STATUS: prdata <= {19'h0, integrate_toggle_cnt, rdy_seen, rb_avail, state};
          REG_RBDATA: prdata <= rb_shift;
          REG_COUNT:  prdata <= {22'h0, bit_cnt};
          default:    prdata <= 32'h0;
        endcase
      end
      if (apb_wr && pready)
      begin
        case (paddr)
          REG_SETUP: setup_word <= pwdata[11:0] & SETUP_KEEP;
          REG_CTRL:
          begin
            do_write <= pwdata[C_WRITE];
            do_read  <= pwdata[C_READBACK];
            do_start <= pwdata[C_START];
            do_step  <= pwdata[C_RBSTEP];
          end
          default: ;
        endcase
      end
    end
  end

  // sequencer for reset, shifting, gaps and readback
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_IDLE;
      tmr      <= 16'h0;
      bit_cnt  <= 10'h0;
      sclk     <= 1'b0;
      rb_shift <= 32'h0;
      rb_avail <= 1'b0;
      rb_done  <= 1'b0;
      pins     <= '{reset_n: 1'b1, default: 1'b0};
    end
    else if (clk_en)
    begin
      tmr <= tmr + 16'h1;
      // single device, chain input held low
      pins.chain_data_in <= 1'b0;
      // ack comes first so a word finishing in the same cycle keeps its flag
      if (do_step)
        rb_avail <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          tmr <= 16'h0;
          if (do_write)
          begin
            pins.integrate_toggle <= 1'b0;
            pins.reset_n          <= 1'b0;
            rb_done               <= 1'b0;
            state                 <= ST_RST;
          end
          else if (do_read && !rb_done)
          begin
            bit_cnt <= 10'h0;
            state   <= ST_GAP;
          end
          else if (do_start)
          begin
            pins.integrate_toggle <= ~pins.integrate_toggle;
            state                 <= ST_RUN;
          end
        end
        ST_RST:
          // reset held for at least 1 us
          if (tmr == 16'(RESET_CYC - 1))
          begin
            pins.reset_n <= 1'b1;
            tmr          <= 16'h0;
            state        <= ST_WAIT;
          end
        ST_WAIT:
          // 2 us before first shift edge
          if (tmr == 16'(WAIT_RST_CYC - 1))
          begin
            tmr     <= 16'h0;
            bit_cnt <= 10'h0;
            pins.cfg_serial_in <= setup_word[SETUP_BITS-1];
            state   <= ST_SHIFT;
          end
        ST_SHIFT:
          if (half_tick)
          begin
            tmr                  <= 16'h0;
            pins.cfg_shift_clock <= ~pins.cfg_shift_clock;
            if (pins.cfg_shift_clock)
            begin
              bit_cnt <= bit_cnt + 10'h1;
              if (bit_cnt == 10'(SETUP_BITS - 1))
                state <= ST_IDLE;
            end
            else
              // msb first, data moves half a period clear of the sampling edge
              pins.cfg_serial_in <= setup_word[4'(SETUP_BITS - 1) - bit_cnt[3:0]];
          end
        ST_GAP:
          // 2 us from readback command to readback start, so at least 2 us after write end
          if (tmr == 16'(WAIT_WR_CYC - 1))
          begin
            tmr   <= 16'h0;
            state <= ST_READ;
          end
        ST_READ:
          if (half_tick)
          begin
            tmr  <= 16'h0;
            sclk <= ~sclk;
            pins.readout_clock <= ~sclk;
            if (sclk)
            begin
              // sample before next rising edge shifts
              // 20-bit tail arrives in the last bits
              rb_shift <= {rb_shift[30:0], sync_rd[1]};
              bit_cnt  <= bit_cnt + 10'h1;
              if (bit_cnt[4:0] == 5'h1f)
                rb_avail <= 1'b1;
              if (bit_cnt == rb_total - 10'h1)
              begin
                rb_done <= 1'b1;
                state   <= ST_IDLE;
              end
            end
          end
        ST_RUN:
        begin
          tmr <= 16'h0;
          if (do_write)
            state <= ST_IDLE;
          else if (do_start)
            pins.integrate_toggle <= ~pins.integrate_toggle;
          // react only to a low ready
          else if (!sync_rdy[1] && !rdy_seen)
            state <= ST_DRAIN;
        end
        ST_DRAIN:
          // one readout clock pulse releases ready
          if (half_tick)
          begin
            tmr <= 16'h0;
            sclk <= ~sclk;
            pins.readout_clock <= ~sclk;
            if (sclk)
              state <= ST_RUN;
          end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // count conversions after reset, results valid from the fifth
  // ready synchronised, so phase jitter is absorbed
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      integrate_toggle_cnt <= 3'h0;
      rdy_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == ST_RST)
        integrate_toggle_cnt <= 3'h0;
      else if (state == ST_DRAIN && half_tick && sclk && integrate_toggle_cnt != 3'(MIN_INTEGRATE_TOGGLE))
        integrate_toggle_cnt <= integrate_toggle_cnt + 3'h1;
      if (state == ST_DRAIN)
        rdy_seen <= 1'b1;
      else if (sync_rdy[1])
        rdy_seen <= 1'b0;
    end
  end

endmodule

// ### include/acsp_pkg.sv
/*
  acsp_pkg: constants, states and carrier types for the setup-port controller
  of a multichannel current-input converter.
  assumes: clk_sys at 200 MHz; all times converted to clk_sys cycles here.
*/
package acsp_pkg;

  localparam int unsigned CLK_MHZ        = 200;
  // serial timing in microseconds as printed
  localparam int unsigned RESET_US       = 1;
  localparam int unsigned WAIT_RST_US    = 2;
  localparam int unsigned WAIT_WR_US     = 2;
  localparam int unsigned RESET_CYC      = RESET_US * CLK_MHZ;
  localparam int unsigned WAIT_RST_CYC   = WAIT_RST_US * CLK_MHZ;
  localparam int unsigned WAIT_WR_CYC    = WAIT_WR_US * CLK_MHZ;
  // half period of generated shift/readout clock, in clk_sys cycles
  localparam int unsigned HALF_CYC       = 8;

  localparam int unsigned SETUP_BITS     = 12;
  localparam int unsigned RB_BITS_16     = 512;
  localparam int unsigned RB_BITS_20     = 640;
  localparam int unsigned MIN_INTEGRATE_TOGGLE       = 4;

  // setup word fields
  localparam int unsigned F_RANGE_LSB    = 9;
  localparam int unsigned F_WIDTH        = 8;
  localparam int unsigned F_SPEED        = 7;
  localparam int unsigned F_DIV4         = 6;
  localparam int unsigned F_TEST         = 0;
  localparam logic [11:0] SETUP_RESET    = 12'h900;
  localparam logic [11:0] SETUP_KEEP     = 12'hfc1;

  // apb register byte offsets
  localparam logic [7:0]  REG_SETUP      = 8'h00;
  localparam logic [7:0]  REG_CTRL       = 8'h04;
  localparam logic [7:0]  REG_STATUS     = 8'h08;
  localparam logic [7:0]  REG_RBDATA     = 8'h0c;
  localparam logic [7:0]  REG_COUNT      = 8'h10;
  // ctrl bits (write 1 pulses)
  localparam int unsigned C_WRITE        = 0;
  localparam int unsigned C_READBACK     = 1;
  localparam int unsigned C_START        = 2;
  localparam int unsigned C_RBSTEP       = 3;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_RST   = 8'h02,
    ST_WAIT  = 8'h04,
    ST_SHIFT = 8'h08,
    ST_GAP   = 8'h10,
    ST_READ  = 8'h20,
    ST_RUN   = 8'h40,
    ST_DRAIN = 8'h80
  } acsp_state_type;

  typedef struct packed {
    logic reset_n;
    logic integrate_toggle;
    logic cfg_shift_clock;
    logic cfg_serial_in;
    logic readout_clock;
    logic chain_data_in;
  } acsp_pins_out_type;

endpackage

// ### verification/acsp_dev_model.sv
/* acsp_dev_model: behavioural converter as seen at its pins.
   assumes: driven only by the acsp_host pins; needs no clock. */
`timescale 1ns/100ps
module acsp_dev_model
  import acsp_pkg::*;
#(
  parameter logic [3:0] REV_ID = 4'h3 // arbitrary value
)(
  input  wire acsp_pins_out_type pins,
  output logic                   readout_data_out,
  output logic                   result_ready_n,
  output logic [11:0]            cfg_word,
  output int                     cfg_cnt,
  output int                     rb_cnt
);
  logic [639:0] rb_sr;
  initial
  begin
    cfg_word = 12'h900;
    result_ready_n = 1'b1;
    readout_data_out = 1'b0;
    rb_sr = '0;
    rb_cnt = 0;
    cfg_cnt = 0;
  end
  always @(negedge pins.cfg_shift_clock or negedge pins.reset_n)
    if (!pins.reset_n)
      cfg_cnt = 0;
    else
    begin
      cfg_word = {cfg_word[10:0], pins.cfg_serial_in};
      cfg_cnt++;
      if (cfg_cnt == 12)
      begin
        rb_cnt = 0;
        rb_sr = cfg_word[8] ? {2{cfg_word, REV_ID, 232'h0, 72'h30f066012480f69055}}
                            : {{2{cfg_word, REV_ID, 184'h0, 56'h30f066012480f6}}, 128'h0};
      end
    end
  // each rising edge puts out the next bit, chain fills behind
  always @(posedge pins.readout_clock)
  begin
    readout_data_out = rb_sr[639];
    rb_sr = {rb_sr[638:0], pins.chain_data_in};
    rb_cnt++;
  end
  // ready a while after a toggle; skip the power-up settle
  // fixed delay: phase jitter and mode pauses not modelled
  always @(pins.integrate_toggle)
    if ($time > 0)
      #250 result_ready_n = 1'b0;
  // released by a full readout pulse
  always @(negedge pins.readout_clock)
    result_ready_n = 1'b1;
endmodule

// ### verification/acsp_host_chk.sv
/* acsp_host_chk: port assertions for acsp_host.
   assumes: bound into every acsp_host. */
`timescale 1ns/100ps
module acsp_host_chk
  import acsp_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic [7:0]        paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire acsp_pins_out_type pins
);
  logic [9:0] lo_cnt;
  logic [9:0] since_rst;
  logic [9:0] since_sck;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // saturating, so long idle spans never wrap
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      lo_cnt    <= '0;
      since_rst <= '0;
      since_sck <= '0;
    end
    else
    begin
      lo_cnt    <= pins.reset_n ? '0 : lo_cnt + 10'(lo_cnt != '1);
      since_rst <= !pins.reset_n ? '0 : since_rst + 10'(since_rst != '1);
      since_sck <= pins.cfg_shift_clock ? '0 : since_sck + 10'(since_sck != '1);
    end
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("late apb answer");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready too long");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h10 |-> pslverr)
    else $error("unmapped not refused");
  a_toggle_in_rst: assert property (!pins.reset_n |-> !pins.integrate_toggle)
    else $error("toggle high in reset");
  a_rst_width: assert property ($rose(pins.reset_n) |-> lo_cnt >= 200)
    else $error("reset pulse short");
  a_first_shift: assert property ($rose(pins.cfg_shift_clock) |-> since_rst >= 400)
    else $error("shift too soon");
  a_rb_gap: assert property ($rose(pins.readout_clock) |-> since_sck >= 400)
    else $error("readback too soon");
  a_bit_setup: assert property ($fell(pins.cfg_shift_clock) |-> $stable(pins.cfg_serial_in))
    else $error("data moved at sample");
  a_park_low: assert property ($changed(pins.integrate_toggle) |-> !pins.readout_clock)
    else $error("readout clock high");
  a_chain_tied: assert property (!pins.chain_data_in)
    else $error("chain input not low");
  c_readout: cover property ($rose(pins.readout_clock));
  c_refused: cover property (pready && pslverr);
  c_toggle: cover property ($changed(pins.integrate_toggle));
endmodule
bind acsp_host acsp_host_chk i_acsp_host_chk (
  .clk_sys (clk_sys),
  .rst_n   (rst_n),
  .paddr   (paddr),
  .psel    (psel),
  .penable (penable),
  .pready  (pready),
  .pslverr (pslverr),
  .pins    (pins)
);

// ### verification/acsp_host_bench.sv
/* acsp_host_bench: apb tests of acsp_host against the device model.
   assumes: acsp_host_chk bound in; 5 ns clock. */
`timescale 1ns/100ps
module acsp_host_bench;
  import acsp_pkg::*;
  logic              clk_sys;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  acsp_pins_out_type pins;
  logic              rd_bit;
  logic              rdy_n;
  logic [11:0]       cfg_word;
  int                cfg_cnt;
  int                rb_cnt;
  logic [31:0]       rdat;
  logic              rerr;
  int                err_total;
  int                samples_checked;
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  acsp_host i_acsp_host (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .clk_en           (1'b1),
    .paddr            (paddr),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .pins             (pins),
    .readout_data_out (rd_bit),
    .result_ready_n   (rdy_n)
  );
  acsp_dev_model i_acsp_dev_model (
    .pins             (pins),
    .readout_data_out (rd_bit),
    .result_ready_n   (rdy_n),
    .cfg_word         (cfg_word),
    .cfg_cnt          (cfg_cnt),
    .rb_cnt           (rb_cnt)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= data;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // polls state until idle; acks any pending readback word it sees on the way
  task automatic wait_idle;
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rdat[8] === 1'b1)
        apb(1'b1, REG_CTRL, 32'h8);
    end
    while (rdat[7:0] !== 8'h01);
  endtask
  task automatic t_defaults;
    apb(1'b0, REG_SETUP, 32'h0);
    check(rdat, 32'h900);
    apb(1'b0, REG_STATUS, 32'h0);
    check({24'h0, rdat[7:0]}, 32'h1);
    apb(1'b1, 8'h40, 32'hffffffff);
    check({31'h0, rerr}, 32'h1);
  endtask
  task automatic t_setup(input logic [11:0] wr, input logic [11:0] kept, input int bits, input logic [31:0] tail);
    apb(1'b1, REG_SETUP, {20'h0, wr});
    apb(1'b0, REG_SETUP, 32'h0);
    check(rdat, {20'h0, kept});
    apb(1'b1, REG_CTRL, 32'h1);
    wait_idle();
    check({20'h0, cfg_word}, {20'h0, kept});
    check(32'(cfg_cnt), 32'd12);
    apb(1'b1, REG_CTRL, 32'h2);
    wait_idle();
    check(32'(rb_cnt), 32'(bits));
    apb(1'b0, REG_COUNT, 32'h0);
    check(rdat, 32'(bits));
    apb(1'b0, REG_RBDATA, 32'h0);
    check(rdat, tail);
  endtask
  task automatic t_run(input int convs);
    int   n;
    logic tog;
    tog = pins.integrate_toggle;
    apb(1'b1, REG_CTRL, 32'h4);
    repeat (2) @(posedge clk_sys);
    check({31'h0, pins.integrate_toggle}, {31'h0, ~tog});
    for (n = 0; n < 200 && rdy_n !== 1'b0; n++)
      @(posedge clk_sys);
    for (n = 0; n < 200 && rdy_n !== 1'b1; n++)
      @(posedge clk_sys);
    check({31'h0, rdy_n}, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    check({24'h0, rdat[7:0]}, 32'h40);
    check({29'h0, rdat[12:10]}, 32'(convs));
  endtask
  initial
  begin
    #400000;
    err_total++;
    report_and_stop();
  end
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_defaults();
    t_setup(12'h5ff, 12'h5c1, 640, 32'h80f69055);
    t_setup(12'he41, 12'he41, 512, 32'h012480f6);
    t_run(1);
    t_run(2);
    report_and_stop();
  end
endmodule
